// *** hdl/serial_input_receiver_consts.svh ***
// Constants for the start-stop serial character receiver.
// Assumes inclusion by its bare name from the design.
`ifndef SERIAL_INPUT_RECEIVER_CONSTS_SVH
`define SERIAL_INPUT_RECEIVER_CONSTS_SVH

// APB register byte addresses
`define SIR_ADDR_CTRL 12'h000
`define SIR_ADDR_HALFBIT 12'h004
`define SIR_ADDR_IDLE 12'h008
`define SIR_ADDR_STATUS 12'h00c
`define SIR_ADDR_DATA 12'h010
`define SIR_ADDR_ACK 12'h014

// Control register fields
`define SIR_CTRL_LEN_LSB 0
`define SIR_CTRL_LEN_MSB 1
`define SIR_CTRL_STOP_LSB 2
`define SIR_CTRL_STOP_MSB 3
`define SIR_CTRL_TEST 4
`define SIR_CTRL_BREAK 5

// Status word bit positions
`define SIR_ST_BREAK_IDLE 8
`define SIR_ST_LOST 9
`define SIR_ST_READY 11

// Reset values
`define SIR_CTRL_RST 32'h0000_000f
`define SIR_HALFBIT_RST 16'h0004
`define SIR_IDLE_RST 32'h0000_0400

// Count figures: data starts at count 2, at most 11 pulses
`define SIR_FIRST_DATA 4'h2
`define SIR_MIN_PULSES 7
`define SIR_MAX_PULSES 11

`endif

// *** hdl/serial_input_receiver_pkg.sv ***
// Types shared by the serial input receiver.
// Assumes the constants header is on the include path.
package serial_input_receiver_pkg;

    // Status word seen by the input multiplexer channel
    typedef struct packed {
        logic [3:0] rsvd_hi;
        logic ready;
        logic rsvd10;
        logic lost;
        logic break_idle;
        logic [7:0] data;
    } status_word_t;

    // Bit clock phase sequencer
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_HALF = 2'b01,
        ST_EVEN = 2'b10,
        ST_ODD = 2'b11
    } rx_state_t;

endpackage : serial_input_receiver_pkg

// *** hdl/serial_input_receiver.sv ***
// Start-stop serial character receiver with APB register access.
// Assumes i_line is synchronous to i_clk (1 = marking) and an APB master.
`timescale 1ns/100ps
`default_nettype none
`include "serial_input_receiver_consts.svh"

module serial_input_receiver #(
    parameter int DIV_W = 16,
    parameter int IDLE_W = 32
) (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst_n,
    // APB slave
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [11:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    // Line and operator
    input wire logic i_line,
    output logic o_mark_lamp,
    output logic o_test_lamp,
    // Input multiplexer channel
    input wire logic i_input_ack,
    output serial_input_receiver_pkg::status_word_t o_status
);

    // ------------------------------------------------------------
    // Parameter check
    // ------------------------------------------------------------
    if (DIV_W < 4 || DIV_W > 32 || IDLE_W < 8 || IDLE_W > 32)
    begin : g_bad_param
        $error("serial_input_receiver: unsupported width");
    end

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    serial_input_receiver_pkg::rx_state_t state_q;
    logic [5:0] ctrl_q;
    logic [DIV_W-1:0] half_q;
    logic [IDLE_W-1:0] idle_lim_q;
    logic [DIV_W-1:0] div_q;
    logic [IDLE_W-1:0] idle_cnt_q;
    logic [3:0] left_q;
    logic [3:0] right_q;
    logic [7:0] asm_q;
    logic [7:0] hold_q;
    logic ready_q;
    logic lost_q;
    logic break_q;
    logic idle_q;
    logic stop_seen_q;
    logic [1:0] len_sel;
    logic [1:0] stop_sel;
    logic test_mode;
    logic man_break;
    logic tick;
    logic even_pulse;
    logic stop_evt;
    logic start_evt;
    logic load_pulse;
    logic [3:0] data_bits;
    logic [3:0] stop_cnt;
    logic apb_wr;
    logic apb_rd;
    logic ack_wr;
    logic ack_any;
    logic force_ones;

    // Control fields
    assign len_sel = ctrl_q[`SIR_CTRL_LEN_MSB:`SIR_CTRL_LEN_LSB];
    assign stop_sel = ctrl_q[`SIR_CTRL_STOP_MSB:`SIR_CTRL_STOP_LSB];
    assign test_mode = ctrl_q[`SIR_CTRL_TEST];
    // Manual break only acts while the line is marking
    assign man_break = ctrl_q[`SIR_CTRL_BREAK];
    assign force_ones = man_break && i_line;

    // ------------------------------------------------------------
    // Character length decoding
    // ------------------------------------------------------------
    // Data bits are 5..8; stop event falls mid first stop bit, mid second for 2 bits
    assign data_bits = 4'(len_sel) + 4'h5;
    // Stop selection 0:1 bit 1:1.5 bit (sampled mid-first) 2/3:2 bits
    assign stop_cnt = `SIR_FIRST_DATA + data_bits
        + ((stop_sel >= 2'h2) ? 4'h1 : 4'h0);

    // ------------------------------------------------------------
    // Half-bit divider
    // ------------------------------------------------------------
    // Tick every programmed half-bit; phase alternates even/odd
    assign tick = (state_q != serial_input_receiver_pkg::ST_IDLE)
        && (div_q == half_q);

    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
            div_q <= '0;
        else if (state_q == serial_input_receiver_pkg::ST_IDLE || tick)
            div_q <= '0;
        else
            div_q <= div_q + DIV_W'(1);
    end

    // ------------------------------------------------------------
    // Bit clock sequencer
    // ------------------------------------------------------------
    // Line zero or test mode wakes the clock control
    assign start_evt = (state_q == serial_input_receiver_pkg::ST_IDLE)
        && (!i_line || test_mode);
    // First even pulse ends the half-bit delay at mid start, so every
    // later even pulse lands mid-bit instead of on a bit boundary
    assign even_pulse = tick
        && (state_q == serial_input_receiver_pkg::ST_HALF
            || state_q == serial_input_receiver_pkg::ST_EVEN);
    assign stop_evt = even_pulse && (left_q == stop_cnt);
    // Loading pulse on the even phase of a data count
    assign load_pulse = even_pulse
        && (left_q >= `SIR_FIRST_DATA)
        && (left_q < `SIR_FIRST_DATA + data_bits);

    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
            state_q <= serial_input_receiver_pkg::ST_IDLE;
        else
        begin
            unique case (state_q)
                serial_input_receiver_pkg::ST_IDLE:
                    if (start_evt)
                        state_q <= serial_input_receiver_pkg::ST_HALF;
                serial_input_receiver_pkg::ST_HALF:
                    // Half start pulse elapsed: the clock starts with its
                    // even pulse, so the odd phase follows
                    if (tick)
                        state_q <= serial_input_receiver_pkg::ST_ODD;
                serial_input_receiver_pkg::ST_EVEN:
                    if (tick)
                        state_q <= serial_input_receiver_pkg::ST_ODD;
                serial_input_receiver_pkg::ST_ODD:
                    if (tick)
                        state_q <= stop_seen_q
                            ? serial_input_receiver_pkg::ST_IDLE
                            : serial_input_receiver_pkg::ST_EVEN;
            endcase
        end
    end

    // Stop event remembered until the following odd phase
    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
            stop_seen_q <= 1'b0;
        else if (stop_evt)
            stop_seen_q <= 1'b1;
        else if (tick && state_q == serial_input_receiver_pkg::ST_ODD)
            stop_seen_q <= 1'b0;
    end

    // ------------------------------------------------------------
    // Two-rank counter
    // ------------------------------------------------------------
    // Left rank advances from right on even, right copies on odd
    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            left_q <= 4'h1;
            right_q <= 4'h1;
        end
        else if (state_q == serial_input_receiver_pkg::ST_IDLE)
        begin
            left_q <= 4'h1;
            right_q <= 4'h1;
        end
        else if (even_pulse)
            left_q <= right_q + 4'h1;
        else if (tick && state_q == serial_input_receiver_pkg::ST_ODD)
            right_q <= left_q;
    end

    // ------------------------------------------------------------
    // Assembly register
    // ------------------------------------------------------------
    // Holds the inverted line: spacing reads as one internally
    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
            asm_q <= '0;
        else if (force_ones)
            asm_q <= '1;
        else if (tick && state_q == serial_input_receiver_pkg::ST_ODD
                 && stop_seen_q)
            asm_q <= '0;
        else if (load_pulse)
            asm_q[3'(left_q - `SIR_FIRST_DATA)] <= !i_line;
    end

    // ------------------------------------------------------------
    // Holding register and status flags
    // ------------------------------------------------------------
    assign ack_any = i_input_ack || ack_wr;

    // Data delivered as true levels; a line break yields all zeros, manual break all ones
    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
            hold_q <= '0;
        else if (force_ones)
            hold_q <= '1;
        else if (stop_evt)
            hold_q <= ~asm_q
                & 8'((9'h001 << data_bits) - 9'h001);
    end

    // Set wins over acknowledge for every flag
    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
            ready_q <= 1'b0;
        else if (stop_evt || force_ones)
            ready_q <= 1'b1;
        else if (ack_any)
            ready_q <= 1'b0;
    end

    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
            lost_q <= 1'b0;
        else if ((stop_evt && ready_q) || force_ones)
            lost_q <= 1'b1;
        else if (ack_any)
            lost_q <= 1'b0;
    end

    // Break: the line spaced through data and stop position
    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
            break_q <= 1'b0;
        else if ((stop_evt && !i_line
                  && (asm_q | ~8'((9'h001 << data_bits) - 9'h001)) == 8'hff)
                 || force_ones)
            break_q <= 1'b1;
        else if (ack_any)
            break_q <= 1'b0;
    end

    // ------------------------------------------------------------
    // Idle timeout
    // ------------------------------------------------------------
    // Restarts at each start pulse; idle cleared by a new start
    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
            idle_cnt_q <= '0;
        else if (start_evt && !i_line)
            idle_cnt_q <= '0;
        else if (idle_cnt_q != idle_lim_q)
            idle_cnt_q <= idle_cnt_q + IDLE_W'(1);
    end

    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
            idle_q <= 1'b0;
        else if (start_evt && !i_line)
            idle_q <= 1'b0;
        else if (idle_cnt_q == idle_lim_q - IDLE_W'(1))
            idle_q <= 1'b1;
    end

    // ------------------------------------------------------------
    // Outputs to channel and lamps
    // ------------------------------------------------------------
    // Break and idle merged on one line
    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            o_status <= '0;
            o_mark_lamp <= 1'b0;
            o_test_lamp <= 1'b0;
        end
        else
        begin
            o_status.rsvd_hi <= '0;
            o_status.rsvd10 <= 1'b0;
            o_status.ready <= ready_q;
            o_status.lost <= lost_q;
            o_status.break_idle <= break_q || idle_q;
            o_status.data <= hold_q;
            o_mark_lamp <= i_line;
            o_test_lamp <= test_mode;
        end
    end

    // ------------------------------------------------------------
    // APB register file
    // ------------------------------------------------------------
    // Zero wait states; unmapped addresses answer with slave error
    assign apb_wr = i_psel && i_penable && i_pwrite;
    assign apb_rd = i_psel && i_penable && !i_pwrite;
    assign ack_wr = apb_wr && (i_paddr == `SIR_ADDR_ACK);
    assign o_pready = 1'b1;

    function automatic logic addr_ok(input logic [11:0] a);
        addr_ok = (a == `SIR_ADDR_CTRL) || (a == `SIR_ADDR_HALFBIT)
            || (a == `SIR_ADDR_IDLE) || (a == `SIR_ADDR_STATUS)
            || (a == `SIR_ADDR_DATA) || (a == `SIR_ADDR_ACK);
    endfunction : addr_ok

    assign o_pslverr = i_psel && i_penable && !addr_ok(i_paddr);

    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            ctrl_q <= 6'(`SIR_CTRL_RST);
            half_q <= DIV_W'(`SIR_HALFBIT_RST);
            idle_lim_q <= IDLE_W'(`SIR_IDLE_RST);
        end
        else if (apb_wr)
        begin
            if (i_paddr == `SIR_ADDR_CTRL)
                ctrl_q <= i_pwdata[5:0];
            if (i_paddr == `SIR_ADDR_HALFBIT && i_pwdata[DIV_W-1:0] != '0)
                half_q <= i_pwdata[DIV_W-1:0];
            if (i_paddr == `SIR_ADDR_IDLE && i_pwdata[IDLE_W-1:0] != '0)
                idle_lim_q <= i_pwdata[IDLE_W-1:0];
        end
    end

    // Read data driven combinationally, not registered, in the access cycle
    always_comb
    begin
        o_prdata = '0;
        if (apb_rd)
        begin
            unique case (i_paddr)
                `SIR_ADDR_CTRL: o_prdata = 32'(ctrl_q);
                `SIR_ADDR_HALFBIT: o_prdata = 32'(half_q);
                `SIR_ADDR_IDLE: o_prdata = 32'(idle_lim_q);
                `SIR_ADDR_STATUS: o_prdata = 32'(o_status);
                `SIR_ADDR_DATA: o_prdata = 32'(hold_q);
                default: o_prdata = '0;
            endcase
        end
    end

endmodule : serial_input_receiver
`default_nettype wire

// *** verif/serial_input_receiver_checker.sv ***
// Port checker for the serial input receiver.
// Assumes the receiver package is compiled and the bind below is seen.
`timescale 1ns/100ps
`default_nettype none
// --------
// Checker
// --------
module serial_input_receiver_checker #(
    parameter int DIV_W = 16,
    parameter int IDLE_W = 32
) (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [11:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    input wire logic [31:0] o_prdata,
    input wire logic o_pready,
    input wire logic o_pslverr,
    input wire logic i_line,
    input wire logic o_mark_lamp,
    input wire logic o_test_lamp,
    input wire logic i_input_ack,
    input wire serial_input_receiver_pkg::status_word_t o_status
);
    logic acc;
    logic ack_now;
    // Access edge, and either form of acknowledge
    assign acc = i_psel && i_penable;
    assign ack_now = i_input_ack || (acc && i_pwrite && i_paddr == 12'h014);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);
    a_pready_always: assert property (o_pready)
        else $error("pready low");
    a_prdata_quiet: assert property (!acc |-> o_prdata == 32'h0)
        else $error("read data outside access");
    a_unmapped_err: assert property (acc && i_paddr == 12'h018 |-> o_pslverr)
        else $error("no error on unmapped address");
    a_mark_follow: assert property ($past(i_rst_n)
        |-> o_mark_lamp == $past(i_line))
        else $error("mark lamp does not follow line");
    a_test_lamp: assert property (acc && i_pwrite
        && i_paddr == 12'h000 |-> ##2 o_test_lamp == $past(i_pwdata[4], 2))
        else $error("test lamp wrong");
    a_ack_clears: assert property (ack_now
        |-> ##2 !o_status.ready && !o_status.lost)
        else $error("acknowledge did not clear flags");
    a_ready_holds: assert property (o_status.ready && !ack_now
        && !$past(ack_now) |=> o_status.ready)
        else $error("ready dropped without acknowledge");
    a_lost_ready: assert property (o_status.lost |-> o_status.ready)
        else $error("lost without ready");
    a_status_rsvd: assert property (o_status.rsvd_hi == 4'h0
        && !o_status.rsvd10)
        else $error("reserved status bits set");
endmodule : serial_input_receiver_checker

bind serial_input_receiver serial_input_receiver_checker #(
    .DIV_W(DIV_W), .IDLE_W(IDLE_W)) serial_input_receiver_checker_inst (
    .i_clk(i_clk), .i_rst_n(i_rst_n), .i_psel(i_psel), .i_penable(i_penable),
    .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata),
    .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr),
    .i_line(i_line), .o_mark_lamp(o_mark_lamp), .o_test_lamp(o_test_lamp),
    .i_input_ack(i_input_ack), .o_status(o_status));
`default_nettype wire

// *** verif/serial_line_model.sv ***
// Modem side of the line: sends start-stop characters.
// Assumes the bench calls its tasks; line marks between characters.
`timescale 1ns/100ps
`default_nettype none
// --------
// Line model
// --------
module serial_line_model #(
    parameter int BIT_CLKS = 6
) (
    input wire logic i_clk,
    output logic o_line
);
    // Marking while no character is sent
    initial o_line = 1'b1;
    // Start, data LSB first, two marking stop bits
    task automatic send(input logic [7:0] data, input int bits);
        int k;
        for (k = -1; k < bits + 2; k++)
        begin
            @(posedge i_clk);
            o_line <= (k < 0) ? 1'b0 : (k < bits) ? data[k] : 1'b1;
            repeat (BIT_CLKS - 1) @(posedge i_clk);
        end
    endtask : send
    // Continuous spacing, as a broken circuit looks
    task automatic hold_space(input int clks);
        @(posedge i_clk);
        o_line <= 1'b0;
        repeat (clks) @(posedge i_clk);
        o_line <= 1'b1;
    endtask : hold_space
endmodule : serial_line_model
`default_nettype wire

// *** verif/serial_input_receiver_bench.sv ***
// Self-checking bench for the serial input receiver.
// Assumes the design, the line model and the checker are compiled.
`timescale 1ns/100ps
`default_nettype none
// --------
// Bench
// --------
module serial_input_receiver_bench;
    logic clk, rst_n, psel, penable, pwrite, pready, pslverr;
    logic line, mark_lamp, test_lamp, input_ack;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    serial_input_receiver_pkg::status_word_t status;
    int n_errors = 0;
    int comparisons = 0;
    serial_input_receiver #(.DIV_W(16), .IDLE_W(32))
        serial_input_receiver_inst (
        .i_clk(clk), .i_rst_n(rst_n), .i_psel(psel), .i_penable(penable),
        .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
        .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
        .i_line(line), .o_mark_lamp(mark_lamp), .o_test_lamp(test_lamp),
        .i_input_ack(input_ack), .o_status(status));
    serial_line_model #(.BIT_CLKS(6)) serial_line_model_inst (
        .i_clk(clk), .o_line(line));
    // 25 MHz clock
    initial
    begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    task automatic stop_test();
        $display("errors %0d comparisons %0d", n_errors, comparisons);
        if (n_errors == 0 && comparisons > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : stop_test
    task automatic check(string what, logic [31:0] exp, logic [31:0] got);
        comparisons++;
        if (got !== exp)
        begin
            n_errors++;
            $display("unexpected %s expected %h seen %h", what, exp, got);
        end
    endtask : check
    // One APB transfer; holds the request until pready at an edge
    task automatic apb(input logic wr, input logic [11:0] a,
        input logic [31:0] wd, output logic [31:0] rd, output logic err);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge clk);
        penable <= 1'b1;
        // Look just ahead of each edge, so no race with launched values
        @(negedge clk);
        while (pready !== 1'b1)
            @(negedge clk);
        rd = prdata;
        err = pslverr;
        // Completing edge; only then is the request released
        @(posedge clk);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] rd;
        logic err;
        apb(1'b1, a, d, rd, err);
    endtask : wr
    task automatic rd_chk(string what, logic [11:0] a, logic [31:0] exp);
        logic [31:0] rd;
        logic err;
        apb(1'b0, a, 32'h0, rd, err);
        check(what, exp, rd);
        check("pslverr", {31'h0, a == 12'h018}, {31'h0, err});
    endtask : rd_chk
    // Bounded wait for the ready flag on the status word
    task automatic wait_ready();
        int n;
        n = 0;
        @(negedge clk);
        while (status.ready !== 1'b1 && n < 400)
        begin
            n++;
            @(negedge clk);
        end
        check("ready", 32'h1, {31'h0, status.ready});
    endtask : wait_ready
    task automatic ack_pin();
        @(posedge clk);
        input_ack <= 1'b1;
        @(posedge clk);
        input_ack <= 1'b0;
        repeat (2) @(negedge clk);
        check("ready after ack", 32'h0, {31'h0, status.ready});
    endtask : ack_pin
    task automatic t_reset();
        rd_chk("ctrl", 12'h000, 32'h0000_000f);
        rd_chk("halfbit", 12'h004, 32'h0000_0004);
        rd_chk("idle limit", 12'h008, 32'h0000_0400);
        rd_chk("unmapped", 12'h018, 32'h0);
        check("status reset", 32'h0, {16'h0, status});
        wr(12'h004, 32'h0000_0002);
        wr(12'h008, 32'h0000_00c8);
        wr(12'h000, 32'h0000_0007);
    endtask : t_reset
    task automatic t_char();
        serial_line_model_inst.send(8'ha5, 8);
        wait_ready();
        check("status", 32'h0000_08a5, {16'h0, status});
        rd_chk("data reg", 12'h010, 32'h0000_00a5);
        rd_chk("status reg", 12'h00c, 32'h0000_08a5);
        ack_pin();
        check("status acked", 32'h0000_00a5, {16'h0, status});
    endtask : t_char
    task automatic t_overrun();
        serial_line_model_inst.send(8'h3c, 8);
        serial_line_model_inst.send(8'hc3, 8);
        wait_ready();
        check("overrun", 32'h0000_0ac3, {16'h0, status});
        // Host keeps a space in place of the lost character
        check("host char", 32'h20,
            status.lost ? 32'h20 : {24'h0, status.data});
        wr(12'h014, 32'h0);
        repeat (2) @(negedge clk);
        check("ack reg", 32'h0000_00c3, {16'h0, status});
    endtask : t_overrun
    task automatic t_idle_break();
        repeat (250) @(posedge clk);
        @(negedge clk);
        check("idle", 32'h0000_01c3, {16'h0, status});
        // Spacing past the stop sample, released before restart is possible
        serial_line_model_inst.hold_space(60);
        wait_ready();
        check("break", 32'h0000_0900, {16'h0, status});
        ack_pin();
        check("break acked", 32'h0, {16'h0, status});
    endtask : t_idle_break
    task automatic t_short();
        wr(12'h000, 32'h0000_0004);
        serial_line_model_inst.send(8'h0e, 5);
        wait_ready();
        check("five bits", 32'h0000_080e, {16'h0, status});
        ack_pin();
    endtask : t_short
    task automatic t_test_break();
        wr(12'h000, 32'h0000_0017);
        wait_ready();
        check("test lamp", 32'h1, {31'h0, test_lamp});
        check("test data", 32'h0000_00ff, {24'h0, status.data});
        wr(12'h000, 32'h0000_0007);
        repeat (100) @(posedge clk);
        ack_pin();
        wr(12'h000, 32'h0000_0027);
        repeat (4) @(negedge clk);
        check("manual", 32'h3, {30'h0, status.ready, status.break_idle});
        wr(12'h000, 32'h0000_0007);
        repeat (4) @(posedge clk);
        ack_pin();
    endtask : t_test_break
    // Hang guard, well above the expected run length
    initial
    begin
        repeat (30000) @(posedge clk);
        n_errors++;
        $display("unexpected run length expected done seen timeout");
        stop_test();
    end
    // Main sequence
    initial
    begin
        rst_n = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h0;
        pwdata = 32'h0;
        input_ack = 1'b0;
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        t_reset();
        t_char();
        t_overrun();
        t_idle_break();
        t_short();
        t_test_break();
        stop_test();
    end
endmodule : serial_input_receiver_bench
`default_nettype wire
